// ==== dv/serial_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clock,
  input wire logic txd,
  output logic rxd
);
  int bitCycles;
  initial begin
    rxd = 1'h1;
    bitCycles = 32;
  end
  // 8 data bits, one stop bit, one idle bit after each frame
  task automatic sendFrame(input logic [7:0] v, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, v, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bitCycles) @(posedge clock);
    end
    rxd <= 1'h1;
    repeat (bitCycles) @(posedge clock);
  endtask
  // samples mid-bit; all ones back means no start bit came in time
  task automatic recvFrame(input int maxWait, output logic [9:0] f);
    int n;
    n = 0;
    f = 10'h3FF;
    while (txd !== 1'h0 && n < maxWait) begin
      @(posedge clock);
      n++;
    end
    if (n < maxWait) begin
      repeat (bitCycles / 2) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
        f[i] = txd;
        if (i < 9) repeat (bitCycles) @(posedge clock);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/usart_clock_and_rx_buffer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module usart_clock_and_rx_buffer_bench;
  import usart_pkg::*;
  logic clock, rst_b, rxd, txd, transferClockIn, transferClockOut, transferClockOe_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic txCompleteEvent, dataEmptyEvent, rxCompleteEvent;
  logic [9:0] f;
  int miscompares, check_count;
  usart_core u_dut (
    .clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rxd(rxd), .txd(txd), .transferClockIn(transferClockIn), .transferClockOut(transferClockOut),
    .transferClockOe_b(transferClockOe_b), .txCompleteEvent(txCompleteEvent),
    .dataEmptyEvent(dataEmptyEvent), .rxCompleteEvent(rxCompleteEvent)
  );
  serial_peer u_peer (.clock(clock), .txd(txd), .rxd(rxd));
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(negedge clock);
      aw = aw | (s_axi_awvalid & s_axi_awready);
      w = w | (s_axi_wvalid & s_axi_wready);
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h1;
    @(negedge clock);
    while (!s_axi_bvalid) @(negedge clock);
    @(posedge clock);
    s_axi_bready <= 1'h0;
  endtask
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(negedge clock);
    while (!s_axi_arready) @(negedge clock);
    @(posedge clock);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    @(negedge clock);
    while (!s_axi_rvalid) @(negedge clock);
    d = s_axi_rdata;
    @(posedge clock);
    s_axi_rready <= 1'h0;
  endtask
  task automatic testReset;
    logic idle;
    regRead(ADDR_CTRL, rd);
    check(rd, {19'h0, CTRL_RESET});
    check({31'h0, transferClockOe_b}, 32'h1);
    regWrite(8'h14, 32'hFF);
    regRead(8'h14, rd);
    check(rd, 32'h0);
    regWrite(ADDR_DATA, 32'h5A);
    idle = 1'h1;
    repeat (200) begin
      @(negedge clock);
      idle = idle & txd;
    end
    check({31'h0, idle}, 32'h1);
    @(posedge clock);
  endtask
  // start bit of 0x01 lasts exactly one bit time
  task automatic testRates;
    int cyc[3] = '{32, 16, 2056};
    logic [12:0] mode[3] = '{13'h0602, 13'h0606, 13'h0606};
    logic [11:0] div[3] = '{12'h001, 12'h001, 12'h100};
    int n;
    for (int i = 0; i < 3; i++) begin
      regWrite(ADDR_CTRL, {19'h0, mode[i]});
      regWrite(ADDR_DIV_HIGH, {28'h0, div[i][11:8]});
      regWrite(ADDR_DIV_LOW, {24'h0, div[i][7:0]});
      regWrite(ADDR_DATA, 32'h01);
      @(negedge clock);
      while (txd) @(negedge clock);
      n = 0;
      while (!txd) begin
        @(negedge clock);
        n++;
      end
      check(n, cyc[i]);
      while (!txCompleteEvent) @(negedge clock);
      @(posedge clock);
    end
  endtask
  task automatic testBackToBack;
    regWrite(ADDR_CTRL, 32'h0603);
    regWrite(ADDR_DIV_HIGH, 32'h0);
    regWrite(ADDR_DIV_LOW, 32'h1);
    u_peer.bitCycles = 32;
    fork
      begin
        u_peer.recvFrame(2000, f);
        check({22'h0, f}, {22'h0, 1'h1, 8'hA5, 1'h0});
        u_peer.recvFrame(32, f);
        check({22'h0, f}, {22'h0, 1'h1, 8'h3C, 1'h0});
      end
      begin
        regWrite(ADDR_DATA, 32'hA5);
        // the second word must find the buffer free, or it replaces the first
        while (!dataEmptyEvent) @(negedge clock);
        @(posedge clock);
        regWrite(ADDR_DATA, 32'h3C);
      end
    join
  endtask
  // third frame must wait in the hold register rxHold
  task automatic testRxQueue;
    logic [7:0] v[3] = '{8'h11, 8'h22, 8'h33};
    logic fe[3] = '{1'h0, 1'h1, 1'h0};
    for (int i = 0; i < 3; i++) u_peer.sendFrame(v[i], !fe[i]);
    for (int i = 0; i < 3; i++) begin
      regRead(ADDR_STATUS, rd);
      check({30'h0, rd[7], rd[4]}, {30'h0, 1'h1, fe[i]});
      regRead(ADDR_DATA, rd);
      check({24'h0, rd[7:0]}, {24'h0, v[i]});
    end
    regRead(ADDR_STATUS, rd);
    check({31'h0, rd[7]}, 32'h0);
    check({31'h0, rxCompleteEvent}, 32'h0);
  endtask
  task automatic testSyncClock;
    logic [12:0] other[3] = '{13'h161A, 13'h060A, 13'h0612};
    int n;
    regWrite(ADDR_CTRL, 32'h061A);
    check({31'h0, transferClockOe_b}, 32'h0);
    regWrite(ADDR_DATA, 32'h01);
    @(negedge clock);
    while (transferClockOut) @(negedge clock);
    while (!transferClockOut) @(negedge clock);
    n = 0;
    while (transferClockOut) begin
      @(negedge clock);
      n++;
    end
    while (!transferClockOut) begin
      @(negedge clock);
      n++;
    end
    check(n, 4);
    while (!txCompleteEvent) @(negedge clock);
    @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      regWrite(ADDR_CTRL, {19'h0, other[i]});
      check({31'h0, transferClockOe_b}, 32'h1);
    end
  endtask
  // slave clock of 8 cycles per period runs only while the frame goes out
  task automatic testSlaveClock;
    int n;
    n = 0;
    regWrite(ADDR_CTRL, 32'h060A);
    regWrite(ADDR_DATA, 32'h01);
    fork
      repeat (24) begin
        repeat (4) @(posedge clock);
        transferClockIn <= ~transferClockIn;
      end
      begin
        @(negedge clock);
        while (txd) @(negedge clock);
        while (!txd) begin
          @(negedge clock);
          n++;
        end
      end
    join
    check(n, 8);
  endtask
  task automatic results;
    $display("mismatches %0d, checks %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    results;
  end
  initial begin
    miscompares = 0;
    check_count = 0;
    rst_b = 1'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    transferClockIn = 1'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    testReset;
    testRates;
    testBackToBack;
    testRxQueue;
    testSyncClock;
    testSlaveClock;
    results;
  end
endmodule
bind usart_core usart_core_sva u_sva (
  .clock(clock), .rst_b(rst_b),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rxd(rxd), .txd(txd), .transferClockIn(transferClockIn), .transferClockOut(transferClockOut),
  .transferClockOe_b(transferClockOe_b), .txCompleteEvent(txCompleteEvent),
  .dataEmptyEvent(dataEmptyEvent), .rxCompleteEvent(rxCompleteEvent)
);
`default_nettype wire

// ==== dv/usart_core_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module usart_core_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  input wire logic txd,
  input wire logic transferClockIn,
  input wire logic transferClockOut,
  input wire logic transferClockOe_b,
  input wire logic txCompleteEvent,
  input wire logic dataEmptyEvent,
  input wire logic rxCompleteEvent
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // both channels are latched first, the response follows one edge later
  AST_B_AFTER_W: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  AST_RX_POP: assert property (
    $fell(rxCompleteEvent) |-> $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00))
    else $error("receive queue emptied without a data read");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_OKAY: assert property (s_axi_bvalid || s_axi_rvalid |-> s_axi_bresp == 2'h0 && s_axi_rresp == 2'h0)
    else $error("bad response code");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  AST_TXC_PULSE: assert property (txCompleteEvent |=> !txCompleteEvent)
    else $error("complete pulse too long");
  AST_TXC_STOP: assert property (txCompleteEvent |-> $past(txd))
    else $error("frame ended without stop level");
  // fastest legal bit is two system cycles
  AST_TXD_MIN: assert property ($changed(txd) |=> $stable(txd))
    else $error("serial bit shorter than two cycles");
endmodule
`default_nettype wire

// ==== rtl/baud_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module baud_generator (
  input wire logic clock,
  input wire logic rst_b,
  baud_if.gen bus
);
  import usart_pkg::*;
  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
    logic tick;
  } state_s;
  state_s state;
  state_s next_state;
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!bus.enable || bus.reload) begin
      next_state.count = bus.divisor;
    end else if (state.count == '0) begin
      next_state.count = bus.divisor;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count - 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign bus.tick = state.tick;
endmodule
`default_nettype wire

// ==== rtl/baud_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
  import usart_pkg::*;
  logic [11:0] divisor;
  logic reload;
  logic enable;
  logic tick;
  modport gen (input divisor, input reload, input enable, output tick);
  modport user (output divisor, output reload, output enable, input tick);
endinterface
`default_nettype wire

// ==== rtl/usart_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module usart_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic txd,
  input wire logic transferClockIn,
  output logic transferClockOut,
  output logic transferClockOe_b,
  output logic txCompleteEvent,
  output logic dataEmptyEvent,
  output logic rxCompleteEvent
);
  import usart_pkg::*;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SHIFT = 2'b01,
    RX_HOLD = 2'b10
  } rx_state_e;
  typedef struct packed {
    logic awTaken;
    logic wTaken;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic rValid;
    logic [31:0] rData;
    logic [12:0] ctrl;
    logic [7:0] divLow;
    logic [3:0] divHigh;
    logic txBufFull;
    logic [8:0] txBuf;
    tx_state_e txState;
    logic [12:0] txShift;
    logic [3:0] txBits;
    logic [3:0] txPhase;
    logic txLine;
    logic txDone;
    rx_state_e rxState;
    logic [3:0] rxPhase;
    logic [3:0] rxBits;
    logic [11:0] rxShift;
    logic rxParity;
    rx_entry_s rxHold;
    rx_entry_s [1:0] fifo;
    logic rxHead;
    logic [1:0] rxCount;
    logic rxPendingOverrun;
    logic rxDone;
    logic clkOut;
    logic clkSync0;
    logic clkSync1;
    logic clkPrev;
  } state_s;
  state_s state;
  state_s next_state;
  baud_if baud ();
  baud_generator baudGen (.clock(clock), .rst_b(rst_b), .bus(baud));
  logic powered;
  logic syncMode;
  clock_mode_e mode;
  logic [3:0] ratio;
  logic [3:0] dataBits;
  logic bitTick;
  logic sampleTick;
  logic slaveRise;
  logic slaveFall;
  logic wrFire;
  logic rdFire;
  logic [7:0] rdAddr;
  logic txParity;
  logic txWrite;
  logic [12:0] txMask;
  logic [12:0] txFrame;
  assign powered = !state.ctrl[CTRL_POWER_CUT];
  assign syncMode = state.ctrl[CTRL_SYNC];
  always_comb begin
    if (!syncMode) begin
      mode = state.ctrl[CTRL_DOUBLE] ? MODE_DOUBLE : MODE_ASYNC;
    end else begin
      mode = state.ctrl[CTRL_PIN_DIR] ? MODE_MASTER : MODE_SLAVE;
    end
  end
  always_comb begin
    unique case (mode)
      MODE_ASYNC: ratio = RATIO_NORMAL;
      MODE_DOUBLE: ratio = RATIO_DOUBLE;
      MODE_MASTER: ratio = RATIO_SYNC;
      MODE_SLAVE: ratio = RATIO_SYNC;
    endcase
  end
  assign dataBits = 4'h5 + {1'b0, state.ctrl[CTRL_SIZE_LSB+2:CTRL_SIZE_LSB]};
  // a low byte write reloads with the byte being written, not the stale one
  assign baud.divisor = baud.reload ? {state.divHigh, state.wData[7:0]} : {state.divHigh, state.divLow};
  assign baud.enable = powered;
  assign wrFire = state.awTaken && state.wTaken && !state.bValid;
  assign baud.reload = wrFire && state.awAddr == ADDR_DIV_LOW && state.wStrb[0];
  assign txWrite = wrFire && state.awAddr == ADDR_DATA && state.wStrb[0] && powered;
  // slave edges come from the second stage only, two cycles behind the pin
  assign slaveRise = state.clkSync1 && !state.clkPrev;
  assign slaveFall = !state.clkSync1 && state.clkPrev;
  always_comb begin
    bitTick = 1'b0;
    sampleTick = 1'b0;
    if (mode == MODE_SLAVE) begin
      bitTick = state.ctrl[CTRL_POL] ? slaveFall : slaveRise;
      sampleTick = state.ctrl[CTRL_POL] ? slaveRise : slaveFall;
    end else if (mode == MODE_MASTER) begin
      bitTick = baud.tick && (state.clkOut == state.ctrl[CTRL_POL]);
      sampleTick = baud.tick && (state.clkOut != state.ctrl[CTRL_POL]);
    end else begin
      bitTick = baud.tick && state.txPhase == 4'h0;
      sampleTick = baud.tick;
    end
  end
  always_comb begin
    txParity = ^(state.txBuf & ((9'h001 << dataBits) - 9'h001)) ^ state.ctrl[CTRL_PAR_ODD];
    // data first, parity right above it, ones beyond for the stop bits
    txMask = (13'h0001 << dataBits) - 13'h0001;
    txFrame = ({4'h0, state.txBuf} & txMask) | ~txMask;
    if (state.ctrl[CTRL_PAR_EN] && !txParity) begin
      txFrame = txFrame & ~(13'h0001 << dataBits);
    end
  end
  assign rdFire = s_axi_arvalid && !state.rValid;
  assign rdAddr = s_axi_araddr;
  always_comb begin
    next_state = state;
    next_state.txDone = 1'b0;
    next_state.rxDone = 1'b0;
    if (s_axi_awvalid && !state.awTaken) begin
      next_state.awTaken = 1'b1;
      next_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.wTaken) begin
      next_state.wTaken = 1'b1;
      next_state.wData = s_axi_wdata;
      next_state.wStrb = s_axi_wstrb;
    end
    if (state.bValid && s_axi_bready) begin
      next_state.bValid = 1'b0;
    end
    if (state.rValid && s_axi_rready) begin
      next_state.rValid = 1'b0;
    end
    if (wrFire) begin
      next_state.awTaken = 1'b0;
      next_state.wTaken = 1'b0;
      next_state.bValid = 1'b1;
      unique case (state.awAddr)
        ADDR_CTRL: begin
          if (state.wStrb[0]) next_state.ctrl[7:0] = state.wData[7:0];
          if (state.wStrb[1]) next_state.ctrl[12:8] = state.wData[12:8];
        end
        ADDR_DIV_LOW: if (state.wStrb[0]) next_state.divLow = state.wData[7:0];
        ADDR_DIV_HIGH: if (state.wStrb[0]) next_state.divHigh = state.wData[3:0];
        ADDR_DATA: begin
          if (state.wStrb[0] && powered) begin
            next_state.txBuf = {state.wData[8], state.wData[7:0]};
            next_state.txBufFull = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rdFire) begin
      next_state.rValid = 1'b1;
      unique case (rdAddr)
        ADDR_DATA: begin
          next_state.rData = {23'h0, state.fifo[state.rxHead].data};
          if (state.rxCount != 2'h0) begin
            next_state.rxHead = ~state.rxHead;
            next_state.rxCount = state.rxCount - 2'h1;
          end
        end
        ADDR_CTRL: next_state.rData = {19'h0, state.ctrl};
        ADDR_STATUS: next_state.rData = {24'h0, state.rxCount != 2'h0, !state.txBufFull, state.txState == TX_IDLE,
          state.fifo[state.rxHead].frameError, state.fifo[state.rxHead].overrun,
          state.fifo[state.rxHead].parityError, state.fifo[state.rxHead].data[8], 1'b0};
        ADDR_DIV_LOW: next_state.rData = {24'h0, state.divLow};
        ADDR_DIV_HIGH: next_state.rData = {28'h0, state.divHigh};
        default: next_state.rData = 32'h0;
      endcase
    end
    next_state.clkSync0 = transferClockIn;
    next_state.clkSync1 = state.clkSync0;
    next_state.clkPrev = state.clkSync1;
    if (mode == MODE_MASTER && baud.tick) begin
      next_state.clkOut = ~state.clkOut;
    end
    // transmitter: one bit per bitTick, further divided in async modes
    if (syncMode == 1'b0 && baud.tick) begin
      next_state.txPhase = (state.txPhase == 4'h0) ? ratio : state.txPhase - 4'h1;
    end
    unique case (state.txState)
      TX_IDLE: begin
        next_state.txLine = 1'b1;
        if (state.txBufFull && state.ctrl[CTRL_TX_EN] && powered && bitTick) begin
          next_state.txBits = dataBits + 4'h1 + {3'h0, state.ctrl[CTRL_PAR_EN]} + {3'h0, state.ctrl[CTRL_STOP2]};
          next_state.txLine = 1'b0;
          next_state.txShift = txFrame;
          // a write in the same cycle refills the buffer: the set wins
          next_state.txBufFull = txWrite;
          next_state.txState = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (bitTick) begin
          next_state.txLine = state.txShift[0];
          next_state.txShift = {1'b1, state.txShift[12:1]};
          if (state.txBits == 4'h0) begin
            next_state.txDone = 1'b1;
            next_state.txLine = 1'b1;
            if (state.txBufFull) begin
              next_state.txLine = 1'b0;
              next_state.txShift = txFrame;
              next_state.txBits = dataBits + 4'h1 + {3'h0, state.ctrl[CTRL_PAR_EN]} + {3'h0, state.ctrl[CTRL_STOP2]};
              next_state.txBufFull = txWrite;
            end else begin
              next_state.txState = TX_IDLE;
            end
          end else begin
            next_state.txBits = state.txBits - 4'h1;
          end
        end
      end
      default: next_state.txState = TX_IDLE;
    endcase
    // receiver: async waits half a bit after the start edge, sync samples each sampleTick
    unique case (state.rxState)
      RX_IDLE, RX_HOLD: begin
        if (state.ctrl[CTRL_RX_EN] && powered && sampleTick && !rxd) begin
          // the held character is lost only if the queue cannot take it now
          if (state.rxState == RX_HOLD && next_state.rxCount == 2'h2) begin
            next_state.rxPendingOverrun = 1'b1;
          end
          next_state.rxState = RX_SHIFT;
          next_state.rxPhase = syncMode ? 4'h0 : {1'b0, ratio[3:1]};
          // sync has no mid-bit wait: the detecting sample is the start bit itself
          next_state.rxBits = dataBits + {3'h0, state.ctrl[CTRL_PAR_EN]} + (syncMode ? 4'h0 : 4'h1);
          next_state.rxShift = '0;
          next_state.rxParity = state.ctrl[CTRL_PAR_ODD];
        end
      end
      RX_SHIFT: begin
        if (sampleTick) begin
          next_state.rxPhase = (state.rxPhase == 4'h0) ? (syncMode ? 4'h0 : ratio) : state.rxPhase - 4'h1;
          if (state.rxPhase == 4'h0) begin
            next_state.rxBits = state.rxBits - 4'h1;
            // a start that is high again at mid-bit was a glitch: drop it
            if (!syncMode && state.rxBits == dataBits + {3'h0, state.ctrl[CTRL_PAR_EN]} + 4'h1 && rxd) begin
              next_state.rxState = RX_IDLE;
            end else if (state.rxBits == 4'h0) begin
              next_state.rxHold.data = 9'(state.rxShift >> (4'hC - dataBits - {3'h0, state.ctrl[CTRL_PAR_EN]}));
              next_state.rxHold.frameError = !rxd;
              next_state.rxHold.parityError = state.ctrl[CTRL_PAR_EN] && state.rxParity;
              next_state.rxHold.overrun = state.rxPendingOverrun;
              next_state.rxPendingOverrun = 1'b0;
              next_state.rxState = RX_HOLD;
            end else begin
              next_state.rxShift = {rxd, state.rxShift[11:1]};
              next_state.rxParity = state.rxParity ^ rxd;
            end
          end
        end
      end
      default: next_state.rxState = RX_IDLE;
    endcase
    if (state.rxState == RX_HOLD && next_state.rxCount != 2'h2) begin
      next_state.fifo[state.rxHead ^ next_state.rxCount[0] ^ (next_state.rxHead != state.rxHead)] = state.rxHold;
      next_state.rxCount = next_state.rxCount + 2'h1;
      next_state.rxDone = 1'b1;
      if (next_state.rxState == RX_HOLD) next_state.rxState = RX_IDLE;
    end
    if (!powered) begin
      next_state.txState = TX_IDLE;
      next_state.rxState = RX_IDLE;
      next_state.txLine = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
      state.ctrl <= CTRL_RESET;
      state.txLine <= 1'b1;
    end else begin
      state <= next_state;
    end
  end
  assign s_axi_awready = !state.awTaken;
  assign s_axi_wready = !state.wTaken;
  assign s_axi_bvalid = state.bValid;
  assign s_axi_bresp = 2'b00;
  assign s_axi_arready = !state.rValid;
  assign s_axi_rvalid = state.rValid;
  assign s_axi_rdata = state.rData;
  assign s_axi_rresp = 2'b00;
  assign txd = state.txLine;
  // pin is released in async modes and in slave mode
  assign transferClockOut = state.clkOut;
  assign transferClockOe_b = !(mode == MODE_MASTER && powered);
  assign txCompleteEvent = state.txDone;
  assign dataEmptyEvent = !state.txBufFull && powered;
  assign rxCompleteEvent = state.rxCount != 2'h0;
endmodule
`default_nettype wire

// ==== rtl/usart_pkg.sv ====
package usart_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DIV_LOW = 8'h0C;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h10;
  localparam int DIV_WIDTH = 12;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_DOUBLE = 2;
  localparam int CTRL_SYNC = 3;
  localparam int CTRL_PIN_DIR = 4;
  localparam int CTRL_POL = 5;
  localparam int CTRL_STOP2 = 6;
  localparam int CTRL_PAR_EN = 7;
  localparam int CTRL_PAR_ODD = 8;
  localparam int CTRL_SIZE_LSB = 9;
  localparam int CTRL_POWER_CUT = 12;
  localparam logic [12:0] CTRL_RESET = 13'h1000;
  localparam logic [3:0] RATIO_NORMAL = 4'hF;
  localparam logic [3:0] RATIO_DOUBLE = 4'h7;
  localparam logic [3:0] RATIO_SYNC = 4'h1;
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_DOUBLE = 2'b01,
    MODE_MASTER = 2'b10,
    MODE_SLAVE = 2'b11
  } clock_mode_e;
  typedef struct packed {
    logic [8:0] data;
    logic frameError;
    logic overrun;
    logic parityError;
  } rx_entry_s;
endpackage
